// ### hdl/mct_timer.sv
// five-channel 16-bit timer: counters, compare registers, status flags,
// adc start requests and six motor-drive output levels
// assumes a single AHB-Lite master on hclk; outputs feed pad logic directly
`timescale 1ns/10ps
// Summary of operation
// - a flag read as 1 clears only by a later write of 0
// - an event between that read and the write keeps the flag set
// - channel 4 count equal to cycle a or b raises its adc start
// - adc request cycle registers reset to all ones
// - at crest, trough or channel 4 overflow the cycle buffers load the cycle registers
// - adc request cycle buffer registers reset to all ones
// - adc start linked to skipping, skipping absent: no adc start
// - registers a to d compare; c and d of channels 0,3,4 may buffer
// - when buffering, c feeds a and d feeds b
// - channel 0 register e compares and may raise an adc start
// - channel 0 register f may buffer register e
// - every general register resets to all ones
// - sync-selected channels share counter writes; others stay alone
// - write protect enable gates writes to channel 3/4 counters and a/b registers and to omen, ocr1 and ocr2
// - master enable 0 drives its output pin low
// - the lock bit sets once and stays until reset
// - level source select picks common or per-phase active levels
// - reverse phase holds its initial level until dead time elapses
// - a start bit of 1 runs its counter, 0 stops it
// - overflow sets the overflow flag and counting resumes from zero
module mct_timer
  import mct_pkg::*;
#(
  parameter int DEAD_CNT = mct_pkg::DEAD_CYCLES
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic adc_start_a,
  output logic adc_start_b,
  output logic adc_start_e,
  output logic [mct_pkg::NUM_PINS-1:0] motor_out
);
  import mct_pkg::*;

  logic [7:0] start_reg;
  logic [7:0] sync_reg;
  logic [7:0] wpen_reg;
  logic [7:0] omen_reg;
  logic [7:0] ocr1_reg;
  logic [7:0] ocr2_reg;
  logic [15:0] adcr_reg;
  logic [15:0] adca_reg;
  logic [15:0] adcb_reg;
  logic [15:0] adcba_reg;
  logic [15:0] adcbb_reg;
  logic [7:0] btt_reg;
  logic [7:0] ccc_reg;
  logic [15:0] cnt_reg [NUM_CH];
  logic [15:0] gr_reg [NUM_CH][4];
  logic [15:0] gre_reg;
  logic [15:0] grf_reg;
  logic down_reg;
  logic [5:0] st_reg [NUM_STAT];
  logic [5:0] armed_reg [NUM_STAT];
  logic [15:0] dead_reg;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic rd_pend_reg;
  logic [7:0] rd_addr_reg;

  logic acc;
  logic [7:0] a_addr;
  logic wr_en;
  logic [15:0] wd;
  logic wp_ok;
  logic lock_ok;
  logic [31:0] rdata;
  logic tri_mode;
  logic crest;
  logic trough;
  logic adc_load;
  logic sync_hit;
  logic [NUM_CH-1:0] run;
  logic [NUM_CH-1:0] cnt_wr;
  logic [NUM_CH-1:0] ovf;
  logic [NUM_CH-1:0] buf_ac;
  logic [NUM_CH-1:0] buf_bd;
  logic [3:0] match [NUM_CH];
  logic match_e;
  logic match_f;
  logic [5:0] ev [NUM_STAT];
  logic [5:0] clr [NUM_STAT];
  logic [NUM_PINS-1:0] lvl;
  logic [NUM_PINS-1:0] active;

  // bus decode; anything above the map folds onto one unmapped address
  assign acc = hsel && hready && htrans[1];
  assign a_addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : ADDR_UNMAPPED;
  assign wr_en = wr_pend_reg;
  assign wd = hwdata[15:0];
  assign wp_ok = wpen_reg[WPEN_ACCESS];
  assign lock_ok = !ocr1_reg[OCR1_LOCK];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= RST_ZERO8;
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= RST_ZERO8;
    end
    else
    begin
      wr_pend_reg <= acc && hwrite;
      rd_pend_reg <= acc && !hwrite;
      if (acc)
      begin
        wr_addr_reg <= a_addr;
        rd_addr_reg <= a_addr;
      end
    end
  end

  // reads take one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= !(acc && !hwrite);
      hresp <= 1'b0;
      if (rd_pend_reg)
      begin
        hrdata <= rdata;
      end
    end
  end

  function automatic logic is_prot(input logic [7:0] a);
    is_prot = (a == 8'(OFF_CNT + 3 * CH_STRIDE))
      || (a == 8'(OFF_CNT + 4 * CH_STRIDE))
      || (a == 8'(OFF_GR + 3 * GR_CH_STRIDE))
      || (a == 8'(OFF_GR + 3 * GR_CH_STRIDE + 4))
      || (a == 8'(OFF_GR + 4 * GR_CH_STRIDE))
      || (a == 8'(OFF_GR + 4 * GR_CH_STRIDE + 4))
      || (a == OFF_OMEN) || (a == OFF_OCR1) || (a == OFF_OCR2);
  endfunction : is_prot

  logic wr_ok;
  assign wr_ok = wr_en && (wp_ok || !is_prot(wr_addr_reg));

  // control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      start_reg <= RST_ZERO8;
      sync_reg <= RST_ZERO8;
      wpen_reg <= RST_WPEN;
      omen_reg <= RST_ZERO8;
      ocr1_reg <= RST_ZERO8;
      ocr2_reg <= RST_ZERO8;
      adcr_reg <= RST_CNT;
      btt_reg <= RST_ZERO8;
      ccc_reg <= RST_ZERO8;
      adcba_reg <= RST_ALL_ONES;
      adcbb_reg <= RST_ALL_ONES;
    end
    else if (wr_ok)
    begin
      case (wr_addr_reg)
        OFF_START: start_reg <= {3'b000, hwdata[4:0]};
        OFF_SYNC: sync_reg <= {3'b000, hwdata[4:0]};
        OFF_WPEN: wpen_reg <= {7'b0000000, hwdata[WPEN_ACCESS]};
        OFF_OMEN: if (lock_ok) omen_reg <= {2'b00, hwdata[5:0]};
        OFF_OCR1:
        begin
          // lock bit only ever goes 0 to 1; other bits freeze once it is set
          ocr1_reg[OCR1_LOCK] <= ocr1_reg[OCR1_LOCK] | hwdata[OCR1_LOCK];
          if (lock_ok)
          begin
            ocr1_reg[2:0] <= hwdata[2:0];
          end
        end
        OFF_OCR2: if (lock_ok) ocr2_reg <= {2'b00, hwdata[5:0]};
        OFF_ADCR: adcr_reg <= {9'h000, hwdata[6:0]};
        OFF_ADCBA: adcba_reg <= wd;
        OFF_ADCBB: adcbb_reg <= wd;
        OFF_BTT: btt_reg <= hwdata[7:0];
        OFF_CCC: ccc_reg <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // which channels buffer c/d into a/b; channels 1 and 2 never do
  always_comb
  begin
    buf_ac = '0;
    buf_bd = '0;
    buf_ac[0] = btt_reg[BTT_CH0_AC];
    buf_bd[0] = btt_reg[BTT_CH0_BD];
    buf_ac[3] = btt_reg[BTT_CH3_AC];
    buf_bd[3] = btt_reg[BTT_CH3_BD];
    buf_ac[4] = btt_reg[BTT_CH4_AC];
    buf_bd[4] = btt_reg[BTT_CH4_BD];
  end

  assign run = start_reg[NUM_CH-1:0];
  assign tri_mode = btt_reg[BTT_CH4_TRI];
  assign crest = run[4] && tri_mode && !down_reg
    && (cnt_reg[4] == gr_reg[4][0]);
  assign trough = run[4] && tri_mode && down_reg && (cnt_reg[4] == RST_CNT);
  assign adc_load = crest || trough || ovf[4];

  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      cnt_wr[ch] = wr_ok && (wr_addr_reg == 8'(OFF_CNT + ch * CH_STRIDE));
      ovf[ch] = run[ch] && (cnt_reg[ch] == CNT_MAX)
        && !(ch == 4 && tri_mode);
      for (int r = 0; r < 4; r++)
      begin
        match[ch][r] = run[ch] && (cnt_reg[ch] == gr_reg[ch][r]);
      end
      // a c or d register acting as buffer makes no compare match
      match[ch][2] = match[ch][2] && !buf_ac[ch] && ch != 1 && ch != 2;
      match[ch][3] = match[ch][3] && !buf_bd[ch] && ch != 1 && ch != 2;
    end
    sync_hit = |(cnt_wr & sync_reg[NUM_CH-1:0]);
  end
  assign match_e = run[0] && (cnt_reg[0] == gre_reg);
  assign match_f = run[0] && (cnt_reg[0] == grf_reg)
    && !btt_reg[BTT_CH0_EF];

  // counters
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        cnt_reg[ch] <= RST_CNT;
      end
      down_reg <= 1'b0;
    end
    else
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        // a write to any synced counter loads every synced counter; channels 3 and 4 only while wp_ok
        if (cnt_wr[ch] || (sync_hit && sync_reg[ch]
            && (wp_ok || ch < 3)))
        begin
          cnt_reg[ch] <= wd;
        end
        else if (run[ch])
        begin
          if (ch == 4 && tri_mode && down_reg)
          begin
            cnt_reg[ch] <= trough ? 16'(cnt_reg[ch] + 16'h0001)
              : 16'(cnt_reg[ch] - 16'h0001);
          end
          else if (ch == 4 && crest)
          begin
            cnt_reg[ch] <= 16'(cnt_reg[ch] - 16'h0001);
          end
          else
          begin
            cnt_reg[ch] <= 16'(cnt_reg[ch] + 16'h0001);
          end
        end
      end
      if (!tri_mode || trough)
      begin
        down_reg <= 1'b0;
      end
      else if (crest)
      begin
        down_reg <= 1'b1;
      end
    end
  end

  // general registers; a software write wins over a buffer transfer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        for (int r = 0; r < 4; r++)
        begin
          gr_reg[ch][r] <= RST_ALL_ONES;
        end
      end
      gre_reg <= RST_ALL_ONES;
      grf_reg <= RST_ALL_ONES;
    end
    else
    begin
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        for (int r = 0; r < 4; r++)
        begin
          if (wr_ok && (wr_addr_reg
              == 8'(OFF_GR + ch * GR_CH_STRIDE + r * 4))
              && !(r > 1 && (ch == 1 || ch == 2)))
          begin
            gr_reg[ch][r] <= wd;
          end
          else if (r == 0 && buf_ac[ch] && match[ch][0])
          begin
            gr_reg[ch][0] <= gr_reg[ch][2];
          end
          else if (r == 1 && buf_bd[ch] && match[ch][1])
          begin
            gr_reg[ch][1] <= gr_reg[ch][3];
          end
        end
      end
      if (wr_ok && wr_addr_reg == OFF_GRE)
      begin
        gre_reg <= wd;
      end
      else if (btt_reg[BTT_CH0_EF] && match_e)
      begin
        gre_reg <= grf_reg;
      end
      if (wr_ok && wr_addr_reg == OFF_GRF)
      begin
        grf_reg <= wd;
      end
    end
  end

  // adc request cycle registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      adca_reg <= RST_ALL_ONES;
      adcb_reg <= RST_ALL_ONES;
    end
    else
    begin
      if (wr_ok && wr_addr_reg == OFF_ADCA)
      begin
        adca_reg <= wd;
      end
      else if (adc_load)
      begin
        adca_reg <= adcba_reg;
      end
      if (wr_ok && wr_addr_reg == OFF_ADCB)
      begin
        adcb_reg <= wd;
      end
      else if (adc_load)
      begin
        adcb_reg <= adcbb_reg;
      end
    end
  end

  // skipping is not built here, so any link bit means skipping disabled
  logic no_link;
  assign no_link = (adcr_reg[ADCR_LINK_HI:ADCR_LINK_LO] == 4'h0);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      adc_start_a <= 1'b0;
      adc_start_b <= 1'b0;
      adc_start_e <= 1'b0;
    end
    else
    begin
      adc_start_a <= run[4] && (cnt_reg[4] == adca_reg)
        && adcr_reg[ADCR_EN_A] && no_link;
      adc_start_b <= run[4] && (cnt_reg[4] == adcb_reg)
        && adcr_reg[ADCR_EN_B] && no_link;
      adc_start_e <= match_e && adcr_reg[ADCR_EN_E];
    end
  end

  // status flags: events per status register, clears only when armed
  always_comb
  begin
    for (int i = 0; i < NUM_STAT; i++)
    begin
      ev[i] = '0;
      clr[i] = '0;
    end
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      ev[ch][3:0] = match[ch];
      ev[ch][ST_OVF] = ovf[ch];
    end
    ev[4][ST_UNF] = trough;
    ev[5][ST_E] = match_e;
    ev[5][ST_F] = match_f;
    for (int i = 0; i < NUM_STAT; i++)
    begin
      if (wr_en && wr_addr_reg == ((i < NUM_CH)
          ? 8'(OFF_STAT + i * CH_STRIDE) : OFF_STAT0X))
      begin
        clr[i] = ~wd[5:0] & armed_reg[i] & ~ev[i];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < NUM_STAT; i++)
      begin
        st_reg[i] <= '0;
        armed_reg[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < NUM_STAT; i++)
      begin
        st_reg[i] <= ev[i] | (st_reg[i] & ~clr[i]);
        if (rd_pend_reg && rd_addr_reg == ((i < NUM_CH)
            ? 8'(OFF_STAT + i * CH_STRIDE) : OFF_STAT0X))
        begin
          armed_reg[i] <= st_reg[i] & ~ev[i];
        end
        else
        begin
          // a recurring event demands a fresh read of 1
          armed_reg[i] <= armed_reg[i] & ~ev[i] & ~clr[i];
        end
      end
    end
  end

  // read mux; unmapped and reserved bits read zero
  always_comb
  begin
    rdata = 32'h00000000;
    case (rd_addr_reg)
      OFF_START: rdata[7:0] = start_reg;
      OFF_SYNC: rdata[7:0] = sync_reg;
      OFF_WPEN: rdata[7:0] = wpen_reg;
      OFF_OMEN: rdata[7:0] = omen_reg;
      OFF_OCR1: rdata[7:0] = ocr1_reg;
      OFF_OCR2: rdata[7:0] = ocr2_reg;
      OFF_ADCR: rdata[15:0] = adcr_reg;
      OFF_ADCA: rdata[15:0] = adca_reg;
      OFF_ADCB: rdata[15:0] = adcb_reg;
      OFF_ADCBA: rdata[15:0] = adcba_reg;
      OFF_ADCBB: rdata[15:0] = adcbb_reg;
      OFF_BTT: rdata[7:0] = btt_reg;
      OFF_CCC: rdata[7:0] = ccc_reg;
      OFF_GRE: rdata[15:0] = gre_reg;
      OFF_GRF: rdata[15:0] = grf_reg;
      OFF_STAT0X: rdata[1:0] = st_reg[5][1:0];
      default: ;
    endcase
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      if (rd_addr_reg == 8'(OFF_CNT + ch * CH_STRIDE))
      begin
        rdata[15:0] = cnt_reg[ch];
      end
      if (rd_addr_reg == 8'(OFF_STAT + ch * CH_STRIDE))
      begin
        rdata[5:0] = st_reg[ch];
        rdata[ST_DIR] = (ch == 4) && down_reg;
      end
      for (int r = 0; r < 4; r++)
      begin
        if (rd_addr_reg == 8'(OFF_GR + ch * GR_CH_STRIDE + r * 4)
            && !(r > 1 && (ch == 1 || ch == 2)))
        begin
          rdata[15:0] = gr_reg[ch][r];
        end
      end
    end
  end

  // dead time counted from the start of channel 4
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dead_reg <= RST_CNT;
    end
    else if (!run[4])
    begin
      dead_reg <= RST_CNT;
    end
    else if (dead_reg < 16'(DEAD_CNT))
    begin
      dead_reg <= 16'(dead_reg + 16'h0001);
    end
  end

  // even pins forward phase, odd pins reverse phase of the same pair
  always_comb
  begin
    for (int p = 0; p < NUM_PINS / 2; p++)
    begin
      active[2 * p] = run[4] && (cnt_reg[4] < ((p == 0) ? gr_reg[3][1]
        : gr_reg[4][(p + 1) % 2]));
      active[2 * p + 1] = run[4] && !active[2 * p]
        && (dead_reg >= 16'(DEAD_CNT));
      lvl[2 * p] = ocr1_reg[OCR1_LVL_SRC] ? ocr2_reg[2 * p]
        : ocr1_reg[OCR1_POS_LVL];
      lvl[2 * p + 1] = ocr1_reg[OCR1_LVL_SRC] ? ocr2_reg[2 * p + 1]
        : ocr1_reg[OCR1_NEG_LVL];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      motor_out <= '0;
    end
    else
    begin
      for (int p = 0; p < NUM_PINS; p++)
      begin
        motor_out[p] <= omen_reg[p]
          && (active[p] ? lvl[p] : !lvl[p]);
      end
    end
  end
endmodule : mct_timer

// ### shared/mct_pkg.sv
// constants shared by the multichannel timer register block
// assumes a 32-bit AHB-Lite slave port with word-aligned registers
package mct_pkg;
  localparam int NUM_CH = 5;
  localparam int NUM_PINS = 6;
  localparam int NUM_STAT = 6;
  // register byte offsets
  localparam logic [7:0] OFF_START = 8'h00;
  localparam logic [7:0] OFF_SYNC = 8'h04;
  localparam logic [7:0] OFF_WPEN = 8'h08;
  localparam logic [7:0] OFF_OMEN = 8'h0C;
  localparam logic [7:0] OFF_OCR1 = 8'h10;
  localparam logic [7:0] OFF_OCR2 = 8'h14;
  localparam logic [7:0] OFF_ADCR = 8'h18;
  localparam logic [7:0] OFF_ADCA = 8'h1C;
  localparam logic [7:0] OFF_ADCB = 8'h20;
  localparam logic [7:0] OFF_ADCBA = 8'h24;
  localparam logic [7:0] OFF_ADCBB = 8'h28;
  localparam logic [7:0] OFF_BTT = 8'h2C;
  localparam logic [7:0] OFF_CCC = 8'h30;
  localparam logic [7:0] OFF_CNT = 8'h40;
  localparam logic [7:0] OFF_GR = 8'h60;
  localparam logic [7:0] OFF_GRE = 8'hB0;
  localparam logic [7:0] OFF_GRF = 8'hB4;
  localparam logic [7:0] OFF_STAT = 8'hC0;
  localparam logic [7:0] OFF_STAT0X = 8'hD4;
  localparam logic [7:0] ADDR_UNMAPPED = 8'hFC;
  localparam int CH_STRIDE = 4;
  localparam int GR_CH_STRIDE = 16;
  // reset values
  localparam logic [15:0] RST_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [7:0] RST_WPEN = 8'h01;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // field positions
  localparam int OCR1_POS_LVL = 0;
  localparam int OCR1_NEG_LVL = 1;
  localparam int OCR1_LVL_SRC = 2;
  localparam int OCR1_LOCK = 3;
  localparam int ADCR_EN_A = 0;
  localparam int ADCR_EN_B = 1;
  localparam int ADCR_LINK_LO = 2;
  localparam int ADCR_LINK_HI = 5;
  localparam int ADCR_EN_E = 6;
  localparam int BTT_CH0_AC = 0;
  localparam int BTT_CH0_BD = 1;
  localparam int BTT_CH0_EF = 2;
  localparam int BTT_CH3_AC = 3;
  localparam int BTT_CH3_BD = 4;
  localparam int BTT_CH4_AC = 5;
  localparam int BTT_CH4_BD = 6;
  localparam int BTT_CH4_TRI = 7;
  localparam int WPEN_ACCESS = 0;
  localparam int ST_OVF = 4;
  localparam int ST_UNF = 5;
  localparam int ST_DIR = 7;
  localparam int ST_E = 0;
  localparam int ST_F = 1;
  // timing
  localparam int CLK_MHZ = 20;
  localparam int DEAD_TIME_NS = 1000;
  localparam int DEAD_CYCLES = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
endpackage : mct_pkg

// ### tb/mct_adc_model.sv
// a/d converter stand-in: counts start requests on each trigger line
// assumes the start lines are single-cycle pulses in the hclk domain
`timescale 1ns/10ps
module mct_adc_model
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic adc_start_a,
  input wire logic adc_start_b,
  input wire logic adc_start_e,
  output int n_a,
  output int n_b,
  output int n_e
);
  // one conversion per high cycle; a stuck line shows as a run of counts
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      n_a <= 0;
      n_b <= 0;
      n_e <= 0;
    end
    else
    begin
      n_a <= n_a + int'(adc_start_a);
      n_b <= n_b + int'(adc_start_b);
      n_e <= n_e + int'(adc_start_e);
    end
  end
endmodule : mct_adc_model

// ### tb/mct_timer_sva.sv
// checker for the timer block: bus timing, adc pulses, lock, pin gating
// assumes it is bound to mct_timer and sees only its ports
`timescale 1ns/10ps
module mct_timer_chk
  import mct_pkg::*;
#(
  parameter int DEAD_CNT = 20
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic adc_start_a,
  input wire logic adc_start_b,
  input wire logic adc_start_e,
  input wire logic [mct_pkg::NUM_PINS-1:0] motor_out
);
  logic take;
  logic wr_dp_reg;
  logic [7:0] wa_reg;
  logic wpen_reg;
  logic lock_reg;
  logic [NUM_PINS-1:0] omen_reg;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_dp_reg <= 1'b0;
      wa_reg <= 8'h00;
    end
    else if (hready)
    begin
      wr_dp_reg <= take && hwrite && haddr[31:8] == 24'h000000;
      wa_reg <= haddr[7:0];
    end
  end
  // shadow of protection state; lock is only cleared by reset
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wpen_reg <= 1'b1;
      lock_reg <= 1'b0;
      omen_reg <= '0;
    end
    else if (wr_dp_reg)
    begin
      if (wa_reg == OFF_WPEN)
        wpen_reg <= hwdata[WPEN_ACCESS];
      if (wa_reg == OFF_OCR1 && wpen_reg && hwdata[OCR1_LOCK])
        lock_reg <= 1'b1;
      if (wa_reg == OFF_OMEN && wpen_reg && !lock_reg)
        omen_reg <= hwdata[NUM_PINS-1:0];
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_take;
    take && !hwrite;
  endsequence
  sequence rd_done;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_read_wait: assert property (rd_take |=> rd_done)
    else $error("read answer not after one wait cycle");
  chk_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write inserted a wait cycle");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  chk_unmapped_zero: assert property (take && !hwrite &&
    (haddr[31:8] != 24'h000000 || haddr[7:0] == ADDR_UNMAPPED)
    |=> ##1 hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_adc_a_pulse: assert property (adc_start_a |=> !adc_start_a)
    else $error("start a longer than one cycle");
  chk_adc_b_pulse: assert property ($rose(adc_start_b) |=> !adc_start_b)
    else $error("start b longer than one cycle");
  chk_adc_e_pulse: assert property (adc_start_e |=> $fell(adc_start_e))
    else $error("start e longer than one cycle");
  chk_lock_sticky: assert property (rd_take ##0 haddr[7:0] == OFF_OCR1
    |=> ##1 hrdata[OCR1_LOCK] == lock_reg)
    else $error("lock bit read back wrong");
  chk_pin_gate: assert property (
    (motor_out & ~(omen_reg | $past(omen_reg))) == '0)
    else $error("disabled pin not low");
endmodule : mct_timer_chk
bind mct_timer mct_timer_chk #(.DEAD_CNT(DEAD_CNT)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .adc_start_a(adc_start_a), .adc_start_b(adc_start_b),
  .adc_start_e(adc_start_e), .motor_out(motor_out)
);

// ### tb/mct_timer_tb.sv
// self-checking bench for the timer block: bus master, scenarios, verdict
// assumes one AHB-Lite slave at 20 MHz, hready fed back from hreadyout
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
  fails++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module mct_timer_tb;
  import mct_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic adc_start_a;
  logic adc_start_b;
  logic adc_start_e;
  logic [NUM_PINS-1:0] motor_out;
  int n_a;
  int n_b;
  int n_e;
  int fails;
  int n_tests;
  logic [31:0] rv;
  // short dead time keeps runs brief
  mct_timer #(.DEAD_CNT(2)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .adc_start_a(adc_start_a),
    .adc_start_b(adc_start_b), .adc_start_e(adc_start_e),
    .motor_out(motor_out));
  mct_adc_model adc (.hclk(hclk), .hresetn(hresetn),
    .adc_start_a(adc_start_a), .adc_start_b(adc_start_b),
    .adc_start_e(adc_start_e), .n_a(n_a), .n_b(n_b), .n_e(n_e));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  task automatic wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 40);
    if (hreadyout !== 1'b1)
    begin
      fails++;
      end_of_test();
    end
  endtask : wait_rdy
  // whole-word single transfer; read data lands in rv
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic ck(input logic [7:0] a, input logic [31:0] e,
    input string nm);
    xfer(1'b0, a, 32'h00000000);
    `CHK(nm, e, rv)
  endtask : ck
  task automatic run(input int n);
    repeat (n) @(posedge hclk);
  endtask : run
  task automatic t_reset;
    for (int i = 0; i < 4; i++)
      ck(OFF_ADCA + 8'(4 * i), 32'h0000FFFF, "cyc_buf");
    for (int c = 0; c < NUM_CH; c++)
      ck(OFF_GR + 8'(GR_CH_STRIDE * c), 32'h0000FFFF, "gr_a");
    ck(OFF_GRF, 32'h0000FFFF, "gr_f");
    ck(OFF_WPEN, 32'h00000001, "wpen");
    wr(ADDR_UNMAPPED, 32'h0000FFFF);
    ck(ADDR_UNMAPPED, 32'h00000000, "unmapped");
  endtask : t_reset
  task automatic t_run;
    int e0;
    e0 = n_e;
    wr(OFF_BTT, 32'h00000005);
    wr(OFF_GR, 32'h00000010);
    wr(OFF_GR + 8'h08, 32'h00000040);
    wr(OFF_GRE, 32'h00000010);
    wr(OFF_GRF, 32'h00000050);
    wr(OFF_ADCR, 32'h00000040);
    wr(OFF_START, 32'h00000001);
    run(32);
    wr(OFF_START, 32'h00000000);
    xfer(1'b0, OFF_CNT, 32'h00000000);
    run(4);
    ck(OFF_CNT, rv, "stopped");
    `CHK("moved", 1'b1, rv > 32'h0000001F)
    ck(OFF_GR, 32'h00000040, "c_to_a");
    ck(OFF_GRE, 32'h00000050, "f_to_e");
    `CHK("adc_e", 1, n_e - e0)
    wr(OFF_ADCR, 32'h00000000);
    wr(OFF_BTT, 32'h00000000);
  endtask : t_run
  task automatic t_flags;
    wr(OFF_CNT, 32'h0000FFFE);
    wr(OFF_START, 32'h00000001);
    run(8);
    wr(OFF_START, 32'h00000000);
    ck(OFF_CNT, 32'h00000008, "cnt");
    `CHK("wrap", 1'b1, rv < 32'h00000010)
    wr(OFF_STAT, 32'h00000000);
    ck(OFF_STAT, 32'h0000001B, "ovf_kept");
    wr(OFF_STAT, 32'h000000FF);
    xfer(1'b0, OFF_STAT, 32'h00000000);
    `CHK("ovf_w1", 1'b1, rv[ST_OVF])
    wr(OFF_STAT, 32'h00000000);
    xfer(1'b0, OFF_STAT, 32'h00000000);
    `CHK("ovf_clr", 1'b0, rv[ST_OVF])
    wr(OFF_CNT, 32'h0000FFFE);
    wr(OFF_START, 32'h00000001);
    run(8);
    xfer(1'b0, OFF_STAT, 32'h00000000);
    wr(OFF_CNT, 32'h0000FFFE);
    run(8);
    wr(OFF_STAT, 32'h00000000);
    wr(OFF_START, 32'h00000000);
    xfer(1'b0, OFF_STAT, 32'h00000000);
    `CHK("ovf_again", 1'b1, rv[ST_OVF])
  endtask : t_flags
  task automatic t_adc;
    int a0;
    int b0;
    a0 = n_a;
    b0 = n_b;
    wr(OFF_CNT + 8'h10, 32'h00000000);
    wr(OFF_ADCA, 32'h00000010);
    wr(OFF_ADCB, 32'h00000020);
    wr(OFF_ADCR, 32'h00000003);
    wr(OFF_START, 32'h00000010);
    run(64);
    `CHK("pins_off", 6'h00, motor_out)
    wr(OFF_START, 32'h00000000);
    `CHK("adc_a", 1, n_a - a0)
    `CHK("adc_b", 1, n_b - b0)
    wr(OFF_ADCR, 32'h00000007);
    wr(OFF_CNT + 8'h10, 32'h00000000);
    a0 = n_a;
    b0 = n_b;
    wr(OFF_START, 32'h00000010);
    run(64);
    wr(OFF_START, 32'h00000000);
    `CHK("link_a", 0, n_a - a0)
    `CHK("link_b", 0, n_b - b0)
    wr(OFF_ADCR, 32'h00000000);
    wr(OFF_ADCBA, 32'h00000030);
    ck(OFF_ADCA, 32'h00000010, "no_load");
    wr(OFF_CNT + 8'h10, 32'h0000FFF8);
    wr(OFF_START, 32'h00000010);
    run(16);
    wr(OFF_START, 32'h00000000);
    ck(OFF_ADCA, 32'h00000030, "load_a");
    ck(OFF_ADCB, 32'h0000FFFF, "load_b");
  endtask : t_adc
  task automatic t_sync;
    wr(OFF_SYNC, 32'h00000003);
    wr(OFF_CNT, 32'h00000100);
    ck(OFF_CNT + 8'h04, 32'h00000100, "sync1");
    ck(OFF_CNT + 8'h08, 32'h00000000, "alone2");
    wr(OFF_SYNC, 32'h00000000);
  endtask : t_sync
  task automatic t_prot;
    logic [31:0] v;
    xfer(1'b0, OFF_CNT + 8'h10, 32'h00000000);
    v = rv;
    wr(OFF_WPEN, 32'h00000000);
    wr(OFF_CNT + 8'h10, 32'h00001234);
    wr(OFF_OMEN, 32'h0000003F);
    wr(OFF_WPEN, 32'h00000001);
    ck(OFF_CNT + 8'h10, v, "cnt4_prot");
    ck(OFF_OMEN, 32'h00000000, "omen_prot");
    wr(OFF_OMEN, 32'h0000003F);
    wr(OFF_OCR1, 32'h00000003);
    wr(OFF_GR + 8'h44, 32'h00000000);
    wr(OFF_START, 32'h00000010);
    run(2);
    `CHK("rev_hold", 1'b0, motor_out[5])
    run(6);
    `CHK("rev_on", 1'b1, motor_out[5])
    `CHK("fwd_hi", 1'b1, motor_out[2])
    wr(OFF_OCR2, 32'h00000000);
    wr(OFF_OCR1, 32'h00000007);
    run(4);
    `CHK("fwd_lo", 1'b0, motor_out[2])
    wr(OFF_START, 32'h00000000);
    wr(OFF_OCR1, 32'h0000000F);
    wr(OFF_OCR1, 32'h00000000);
    ck(OFF_OCR1, 32'h0000000F, "lock");
    wr(OFF_OMEN, 32'h00000000);
    ck(OFF_OMEN, 32'h0000003F, "omen_lock");
  endtask : t_prot
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    fails = 0;
    n_tests = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_run();
    t_flags();
    t_adc();
    t_sync();
    t_prot();
    end_of_test();
  end
endmodule : mct_timer_tb
